// file: hdl/aux_monitor_voltage_uv_fault_and_write_lock.sv
`timescale 1ns/1ps
`default_nettype none
module aux_monitor_voltage_uv_fault_and_write_lock #(
    parameter int RETRY_UNIT_CYCLES = uv_lock_pkg::RETRY_UNIT_CYCLES,
    parameter int VOLT_BITS = 12
) (
    input wire logic ref_clk, // 40 MHz system clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic cmd_valid, // Command strobe, one cycle.
    input wire logic cmd_write, // High for write, low for read.
    input wire logic [7:0] cmd_code, // Command code.
    input wire logic [uv_lock_pkg::PRIVATE_PW_BITS-1:0] cmd_wdata, // Write data, low bits first.
    output logic rsp_valid, // Answer strobe, one cycle.
    output logic [7:0] rsp_rdata, // Read data.
    output logic rsp_refused, // Write was refused.
    input wire logic [uv_lock_pkg::MASK_BITS-1:0] user_mask, // User store mask.
    input wire logic [uv_lock_pkg::MASK_BITS-1:0] default_mask, // Default store mask.
    input wire logic [uv_lock_pkg::PRIVATE_PW_BITS-1:0] user_private_pw, // User password.
    input wire logic [uv_lock_pkg::PRIVATE_PW_BITS-1:0] default_private_pw, // Default password.
    input wire logic [uv_lock_pkg::PUBLIC_PW_BITS-1:0] user_public_pw, // Public password.
    input wire logic [VOLT_BITS-1:0] aux_monitor_voltage, // Monitored voltage code.
    input wire logic [VOLT_BITS-1:0] aux_undervoltage_limit, // Undervoltage limit code.
    input wire logic commanded_on, // Output commanded on.
    input wire logic bias_ok, // Bias power present.
    input wire logic other_fault, // Another fault forces shutdown.
    output logic output_enable, // Power stage enable.
    output logic alert_output_line_n, // Alert line, active low.
    output logic aux_uv_fault_flag, // Sticky undervoltage status bit.
    output logic comm_fault_flag // Sticky refused-write status bit.
);
    import uv_lock_pkg::*;

    localparam int PRODUCT_BITS = VOLT_BITS + 5;

    logic [7:0] response_q;
    logic [1:0] tier_q;
    uv_state_t state_q;
    logic uv_flag_q;
    logic comm_flag_q;
    logic out_en_q;
    logic alert_n_q;
    logic rsp_valid_q;
    logic [7:0] rsp_rdata_q;
    logic rsp_refused_q;
    logic write_allowed;
    logic wr_cmd;
    logic clear_cmd;
    logic uv_fault;
    logic uv_recovered;
    logic fault_event;
    logic forced_off;
    logic [1:0] resp_mode;
    logic [2:0] resp_retry;
    logic [PRODUCT_BITS-1:0] volt_scaled;
    logic [PRODUCT_BITS-1:0] limit_scaled;

    retry_timer_if tmr_bus ();

    retry_timer #(
        .UNIT_CYCLES(RETRY_UNIT_CYCLES)
    ) u_retry_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tmr(tmr_bus.timer)
    );

    write_gate u_write_gate (
        .code(cmd_code),
        .tier(tier_q),
        .user_mask(user_mask),
        .default_mask(default_mask),
        .allowed(write_allowed)
    );

    // Decoded command strobes; a refused write reaches no register but the comm fault flag and the refusal answer.
    assign wr_cmd = cmd_valid && cmd_write && write_allowed;
    assign clear_cmd = wr_cmd && (cmd_code == CMD_CLEAR_FAULTS);

    // Response fields.
    assign resp_mode = response_q[RESP_MODE_LSB +: 2];
    assign resp_retry = response_q[RESP_RETRY_LSB +: 3];

    // Fault below the limit; recovery strictly above 105 percent of it.
    // Cross-multiplying avoids a divider at the cost of a wider compare.
    assign volt_scaled = PRODUCT_BITS'(aux_monitor_voltage) * PRODUCT_BITS'(RECOVER_DEN);
    assign limit_scaled = PRODUCT_BITS'(aux_undervoltage_limit) * PRODUCT_BITS'(RECOVER_NUM);
    assign uv_fault = aux_monitor_voltage < aux_undervoltage_limit;
    assign uv_recovered = volt_scaled > limit_scaled;

    // [R1] ignore when mode is 00
    assign fault_event = (state_q == UV_RUN) && out_en_q && uv_fault
        && (resp_mode == MODE_RETRY || resp_mode == MODE_HOLD);

    // [R7] only these stop continuous retries
    assign forced_off = !commanded_on || !bias_ok || other_fault;

    // [R10] [R11] response register, written only when permitted
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            response_q <= AUX_UV_RESPONSE_RST;
        else if (wr_cmd && cmd_code == CMD_AUX_UV_RESPONSE)
            response_q <= cmd_wdata[7:0];
    end

    // [R15] [R18] four-valued authority tier
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            tier_q <= TIER_RST;
        else if (wr_cmd && cmd_code == CMD_PUBLIC_PASSWORD)
        begin
            // [R17] [R19] public sets 0 or 1
            if (cmd_wdata[PUBLIC_PW_BITS-1:0] == user_public_pw)
                tier_q <= TIER_PUBLIC;
            else
                tier_q <= TIER_OPEN;
        end
        else if (wr_cmd && cmd_code == CMD_PRIVATE_PASSWORD)
        begin
            // [R12] [R16] private only raises
            if (cmd_wdata == default_private_pw)
                tier_q <= TIER_MAKER;
            else if (cmd_wdata == user_private_pw && tier_q < TIER_USER)
                tier_q <= TIER_USER;
        end
    end

    // [R2] [R3] sticky undervoltage bit; a new fault beats a clear
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            uv_flag_q <= 1'b0;
        else if (fault_event)
            uv_flag_q <= 1'b1;
        else if (clear_cmd)
            uv_flag_q <= 1'b0;
    end

    // [R21] refused write flag; set wins over clear
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            comm_flag_q <= 1'b0;
        else if (cmd_valid && cmd_write && !write_allowed)
            comm_flag_q <= 1'b1;
        else if (clear_cmd)
            comm_flag_q <= 1'b0;
    end

    // Undervoltage response sequencer.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= UV_RUN;
        else
        begin
            case (state_q)
                UV_RUN:
                begin
                    if (fault_event)
                    begin
                        // [R5] hold until recovery
                        if (resp_mode == MODE_HOLD)
                            state_q <= UV_HOLD;
                        // [R4] [R8] retry after recovery
                        else if (resp_retry == RETRY_FOREVER)
                            state_q <= UV_WAIT_RECOVER;
                        // [R6] no retry; unused codes too
                        else
                            state_q <= UV_LATCHED;
                    end
                end
                UV_LATCHED:
                begin
                    if (clear_cmd)
                        state_q <= UV_RUN;
                end
                UV_HOLD:
                begin
                    if (uv_recovered)
                        state_q <= UV_RUN;
                end
                UV_WAIT_RECOVER:
                begin
                    if (forced_off)
                        state_q <= UV_RUN;
                    else if (uv_recovered)
                        state_q <= UV_WAIT_DELAY;
                end
                UV_WAIT_DELAY:
                begin
                    // [R7] restart without re-checking
                    if (forced_off || tmr_bus.expired)
                        state_q <= UV_RUN;
                end
                default:
                    state_q <= UV_RUN;
            endcase
        end
    end

    // [R9] timer starts on each shutdown
    assign tmr_bus.start = fault_event;
    assign tmr_bus.delay_code = response_q[RESP_DELAY_LSB +: 3];

    // [R4] output drops in the cycle after the fault
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            out_en_q <= 1'b0;
        else
            out_en_q <= !forced_off && !fault_event
                && (state_q == UV_RUN || (state_q == UV_WAIT_DELAY && tmr_bus.expired)
                || (state_q == UV_HOLD && uv_recovered)
                || (state_q == UV_LATCHED && clear_cmd));
    end

    // [R2] alert low while a status bit stands
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            alert_n_q <= 1'b1;
        else
            alert_n_q <= !(uv_flag_q || comm_flag_q);
    end

    // [R11] reads are always answered
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
            rsp_refused_q <= 1'b0;
        end
        else
        begin
            rsp_valid_q <= cmd_valid;
            rsp_refused_q <= cmd_valid && cmd_write && !write_allowed;
            if (cmd_valid && !cmd_write && cmd_code == CMD_AUX_UV_RESPONSE)
                rsp_rdata_q <= response_q;
            else if (cmd_valid && !cmd_write && cmd_code == CMD_WRITE_AUTHORITY_TIER)
                rsp_rdata_q <= {6'h00, tier_q};
            else
                rsp_rdata_q <= 8'h00;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_rdata_q;
    assign rsp_refused = rsp_refused_q;
    assign output_enable = out_en_q;
    assign alert_output_line_n = alert_n_q;
    assign aux_uv_fault_flag = uv_flag_q;
    assign comm_fault_flag = comm_flag_q;
endmodule : aux_monitor_voltage_uv_fault_and_write_lock
`default_nettype wire

// file: hdl/retry_timer.sv
`timescale 1ns/1ps
`default_nettype none
module retry_timer #(
    parameter int UNIT_CYCLES = uv_lock_pkg::RETRY_UNIT_CYCLES
) (
    input wire logic ref_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    retry_timer_if.timer tmr // Start and expiry.
);
    import uv_lock_pkg::*;

    logic [31:0] cycle_q;
    logic [3:0] units_q;
    logic [3:0] target_q;
    logic running_q;
    logic expired_q;
    logic unit_tick;

    // One-cycle enable at the end of each retry unit.
    assign unit_tick = running_q && (cycle_q == 32'(UNIT_CYCLES - 1));

    // Cycle divider; restarts on every start so the first unit is whole.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cycle_q <= 32'h0;
        else if (tmr.start || unit_tick || !running_q)
            cycle_q <= 32'h0;
        else
            cycle_q <= cycle_q + 32'h1;
    end

    // [R9] delay unit count
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            units_q <= 4'h0;
            target_q <= 4'h1;
            running_q <= 1'b0;
            expired_q <= 1'b0;
        end
        else
        begin
            if (tmr.start)
            begin
                expired_q <= 1'b0;
                units_q <= 4'h0;
                target_q <= {1'b0, tmr.delay_code} + 4'h1;
                running_q <= 1'b1;
            end
            else if (unit_tick)
            begin
                units_q <= units_q + 4'h1;
                if (units_q + 4'h1 == target_q)
                begin
                    running_q <= 1'b0;
                    expired_q <= 1'b1;
                end
            end
        end
    end

    assign tmr.expired = expired_q;
endmodule : retry_timer
`default_nettype wire

// file: hdl/retry_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
// Start request and expiry between the fault controller and its retry timer.
interface retry_timer_if;
    logic start;
    logic [2:0] delay_code;
    logic expired;

    modport ctrl (output start, output delay_code, input expired);
    modport timer (input start, input delay_code, output expired);
endinterface : retry_timer_if
`default_nettype wire

// file: hdl/uv_lock_pkg.sv
// Functional notes
// [R1] Response mode 00 ignores undervoltage faults.
// [R2] Active response pulls alert low, sets fault bit.
// [R3] Fault bits cleared only by CLEAR_FAULTS.
// [R4] Mode 10 disables at once, then retries.
// [R5] Mode 11 holds off until above 105%.
// [R6] Retry code 000 stays off until cleared.
// [R7] Retry code 111 restarts continuously without checking.
// [R8] Continuous retry waits for voltage above 105%.
// [R9] Retry spacing is (delay code + 1) times 35 ms.
// [R10] Response register resets to BFh.
// [R11] Write permission per command mask bit; reads free.
// [R12] User and default stores keep own masks, passwords.
// [R13] Default-cleared commands need default private password.
// [R14] User-cleared commands need user private password.
// [R15] Four tiers; 0/1 public, higher need private.
// [R16] Private password writes only raise the tier.
// [R17] Public password write sets tier 0 or 1.
// [R18] Four tiers for maker down to end user.
// [R19] Tier 1 only on user public password match; reset loads tier 1 without one.
// [R20] Mask bit index equals command code.
// [R21] Refused writes are dropped and flagged.
`default_nettype none
package uv_lock_pkg;
    // Command codes of this block; CMD_PROTECT_MASK is defined here but is not handled by the block.
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_AUX_UV_RESPONSE = 8'hF9;
    localparam logic [7:0] CMD_WRITE_AUTHORITY_TIER = 8'hFA;
    localparam logic [7:0] CMD_PRIVATE_PASSWORD = 8'hFB;
    localparam logic [7:0] CMD_PUBLIC_PASSWORD = 8'hFC;
    localparam logic [7:0] CMD_PROTECT_MASK = 8'hFD;

    // Reset values.
    localparam logic [7:0] AUX_UV_RESPONSE_RST = 8'hBF;
    localparam logic [1:0] TIER_RST = 2'h1;

    // Response register field positions.
    localparam int RESP_MODE_LSB = 6;
    localparam int RESP_RETRY_LSB = 3;
    localparam int RESP_DELAY_LSB = 0;

    // Response modes in bits 7:6 and retry settings in bits 5:3.
    localparam logic [1:0] MODE_IGNORE = 2'h0;
    localparam logic [1:0] MODE_UNUSED = 2'h1;
    localparam logic [1:0] MODE_RETRY = 2'h2;
    localparam logic [1:0] MODE_HOLD = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Authority tiers.
    localparam logic [1:0] TIER_OPEN = 2'h0;
    localparam logic [1:0] TIER_PUBLIC = 2'h1;
    localparam logic [1:0] TIER_USER = 2'h2;
    localparam logic [1:0] TIER_MAKER = 2'h3;

    // Password and mask widths.
    localparam int PRIVATE_PW_BITS = 72;
    localparam int PUBLIC_PW_BITS = 32;
    localparam int MASK_BITS = 256;

    // Recovery threshold of 105 percent as the ratio 21/20.
    localparam logic [4:0] RECOVER_NUM = 5'h15;
    localparam logic [4:0] RECOVER_DEN = 5'h14;

    // Retry time unit.
    localparam int RETRY_UNIT_MS = 35;
    localparam int CLK_FREQ_HZ = 40000000;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * (CLK_FREQ_HZ / 1000);

    // Undervoltage response states.
    typedef enum logic [2:0] {
        UV_RUN,
        UV_LATCHED,
        UV_WAIT_RECOVER,
        UV_WAIT_DELAY,
        UV_HOLD
    } uv_state_t;
endpackage : uv_lock_pkg
`default_nettype wire

// file: hdl/write_gate.sv
`timescale 1ns/1ps
`default_nettype none
module write_gate (
    input wire logic [7:0] code, // Command code of the write.
    input wire logic [1:0] tier, // Current authority tier.
    input wire logic [uv_lock_pkg::MASK_BITS-1:0] user_mask, // User store mask.
    input wire logic [uv_lock_pkg::MASK_BITS-1:0] default_mask, // Default store mask.
    output logic allowed // Write may proceed.
);
    import uv_lock_pkg::*;

    // Password commands are never protectable, so tier 0 can always climb back.
    always_comb
    begin
        allowed = 1'b0;
        if (code == CMD_PUBLIC_PASSWORD || code == CMD_PRIVATE_PASSWORD)
            allowed = 1'b1;
        // [R20] [R13] default mask check
        else if (!default_mask[code])
            allowed = (tier >= TIER_MAKER);
        // [R14] user mask check
        else if (!user_mask[code])
            allowed = (tier >= TIER_USER);
        // [R11] open commands need public tier
        else
            allowed = (tier >= TIER_PUBLIC);
    end
endmodule : write_gate
`default_nettype wire

// file: test/aux_monitor_voltage_uv_fault_and_write_lock_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aux_monitor_voltage_uv_fault_and_write_lock_tb;
    import uv_lock_pkg::*;
    localparam int UNIT = 10;
    localparam logic [31:0] UPUB = 32'h5A3C_1F07;
    localparam logic [71:0] UPRIV = 72'h11_2233_4455_6677_8899;
    localparam logic [71:0] DPRIV = 72'hA1_B2C3_D4E5_F607_1829;
    logic ref_clk, rst_n, cmd_valid, cmd_write, rsp_valid, rsp_refused;
    logic commanded_on, bias_ok, other_fault, output_enable, alert_output_line_n;
    logic aux_uv_fault_flag, comm_fault_flag;
    logic [7:0] cmd_code, rsp_rdata;
    logic [71:0] cmd_wdata;
    logic [255:0] user_mask, default_mask;
    logic [11:0] aux_monitor_voltage, aux_undervoltage_limit;
    int fail_count = 0;
    int n_checks = 0;

    aux_monitor_voltage_uv_fault_and_write_lock #(.RETRY_UNIT_CYCLES(UNIT), .VOLT_BITS(12)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_refused(rsp_refused), .user_mask(user_mask),
        .default_mask(default_mask), .user_private_pw(UPRIV), .default_private_pw(DPRIV),
        .user_public_pw(UPUB), .aux_monitor_voltage(aux_monitor_voltage),
        .aux_undervoltage_limit(aux_undervoltage_limit), .commanded_on(commanded_on),
        .bias_ok(bias_ok), .other_fault(other_fault), .output_enable(output_enable),
        .alert_output_line_n(alert_output_line_n), .aux_uv_fault_flag(aux_uv_fault_flag),
        .comm_fault_flag(comm_fault_flag));

    uv_host_model u_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_refused(rsp_refused));

    // Free-running 40 MHz clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    begin
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string what);
    begin
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: %s is %b", $time, what, got);
        end
    end
    endtask : chk1

    task automatic wr(input logic [7:0] code, input logic [71:0] data, input logic exp_ref);
        logic [7:0] rd_v;
        logic ref_v;
    begin
        u_host.xfer(1'b1, code, data, rd_v, ref_v);
        chk1(ref_v, exp_ref, "refusal");
    end
    endtask : wr

    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        logic [7:0] rd_v;
        logic ref_v;
    begin
        u_host.xfer(1'b0, code, 72'h0, rd_v, ref_v);
        chk8(rd_v, exp);
    end
    endtask : rd

    // Drops the voltage, holds it low, then counts cycles until the output returns.
    task automatic retry_run(input logic [2:0] dly, input int hold);
        int k;
        int e;
    begin
        wr(CMD_AUX_UV_RESPONSE, {64'h0, 5'h17, dly}, 1'b0);
        aux_monitor_voltage = 12'h100;
        repeat (hold) @(negedge ref_clk);
        chk1(output_enable, 1'b0, "retry early");
        aux_monitor_voltage = 12'h200;
        e = ((dly + 1) * UNIT > hold) ? (dly + 1) * UNIT - hold : 0;
        k = 0;
        while (output_enable !== 1'b1 && k < 200)
        begin
            @(negedge ref_clk);
            k++;
        end
        chk1(k + 3 >= e && k <= e + 3, 1'b1, "retry spacing");
        wr(CMD_CLEAR_FAULTS, 72'h0, 1'b0);
    end
    endtask : retry_run

    task automatic print_verdict();
    begin
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask : print_verdict

    // Cuts a hang short well beyond the expected run.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial
    begin
        rst_n = 1'b0;
        user_mask = '1;
        default_mask = '1;
        aux_monitor_voltage = 12'h200;
        aux_undervoltage_limit = 12'h190;
        commanded_on = 1'b1;
        bias_ok = 1'b1;
        other_fault = 1'b0;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        rd(CMD_AUX_UV_RESPONSE, AUX_UV_RESPONSE_RST);
        rd(CMD_WRITE_AUTHORITY_TIER, 8'h01);
        // A wrong public password locks ordinary writes.
        wr(CMD_PUBLIC_PASSWORD, 72'h0, 1'b0);
        rd(CMD_WRITE_AUTHORITY_TIER, 8'h00);
        wr(CMD_AUX_UV_RESPONSE, 72'h0, 1'b1);
        rd(CMD_AUX_UV_RESPONSE, 8'hBF);
        chk1(comm_fault_flag, 1'b1, "comm flag");
        chk1(alert_output_line_n, 1'b0, "alert");
        wr(CMD_PUBLIC_PASSWORD, {40'h0, UPUB}, 1'b0);
        rd(CMD_WRITE_AUTHORITY_TIER, 8'h01);
        // A cleared neighbour bit must not lock this command.
        user_mask[8'hF8] = 1'b0;
        wr(CMD_AUX_UV_RESPONSE, 72'hBF, 1'b0);
        user_mask[CMD_AUX_UV_RESPONSE] = 1'b0;
        wr(CMD_AUX_UV_RESPONSE, 72'h0, 1'b1);
        wr(CMD_PRIVATE_PASSWORD, UPRIV, 1'b0);
        rd(CMD_WRITE_AUTHORITY_TIER, 8'h02);
        wr(CMD_AUX_UV_RESPONSE, 72'hBF, 1'b0);
        default_mask[CMD_AUX_UV_RESPONSE] = 1'b0;
        wr(CMD_AUX_UV_RESPONSE, 72'h0, 1'b1);
        wr(CMD_PRIVATE_PASSWORD, DPRIV, 1'b0);
        rd(CMD_WRITE_AUTHORITY_TIER, 8'h03);
        wr(CMD_PRIVATE_PASSWORD, UPRIV, 1'b0);
        rd(CMD_WRITE_AUTHORITY_TIER, 8'h03);
        wr(CMD_AUX_UV_RESPONSE, 72'hBF, 1'b0);
        wr(CMD_PUBLIC_PASSWORD, {40'h0, UPUB}, 1'b0);
        rd(CMD_WRITE_AUTHORITY_TIER, 8'h01);
        user_mask = '1;
        default_mask = '1;
        wr(CMD_CLEAR_FAULTS, 72'h0, 1'b0);
        chk1(comm_fault_flag, 1'b0, "comm clear");
        // Ignore mode: a deep dip leaves the output running.
        wr(CMD_AUX_UV_RESPONSE, 72'h0, 1'b0);
        aux_monitor_voltage = 12'h100;
        repeat (6) @(negedge ref_clk);
        chk1(aux_uv_fault_flag, 1'b0, "ignored flag");
        chk1(output_enable, 1'b1, "ignored enable");
        aux_monitor_voltage = 12'h200;
        // Hold mode: exactly 105 percent is not yet above the threshold.
        wr(CMD_AUX_UV_RESPONSE, 72'hC0, 1'b0);
        aux_monitor_voltage = 12'h100;
        repeat (3) @(negedge ref_clk);
        chk1(aux_uv_fault_flag, 1'b1, "uv flag");
        aux_monitor_voltage = 12'h1A4;
        repeat (4) @(negedge ref_clk);
        chk1(output_enable, 1'b0, "hold at 105");
        aux_monitor_voltage = 12'h1A5;
        repeat (3) @(negedge ref_clk);
        chk1(output_enable, 1'b1, "hold resume");
        chk1(aux_uv_fault_flag, 1'b1, "uv sticky");
        wr(CMD_CLEAR_FAULTS, 72'h0, 1'b0);
        chk1(aux_uv_fault_flag, 1'b0, "uv clear");
        // Latch-off: recovery alone does not restart.
        wr(CMD_AUX_UV_RESPONSE, 72'h80, 1'b0);
        aux_monitor_voltage = 12'h100;
        repeat (3) @(negedge ref_clk);
        aux_monitor_voltage = 12'h200;
        repeat (40) @(negedge ref_clk);
        chk1(output_enable, 1'b0, "latched");
        wr(CMD_CLEAR_FAULTS, 72'h0, 1'b0);
        repeat (2) @(negedge ref_clk);
        chk1(output_enable, 1'b1, "unlatched");
        retry_run(3'h0, 30);
        retry_run(3'h7, 2);
        // Forced-off inputs stop the output.
        commanded_on = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk1(output_enable, 1'b0, "commanded off");
        commanded_on = 1'b1;
        bias_ok = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk1(output_enable, 1'b0, "bias lost");
        bias_ok = 1'b1;
        other_fault = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk1(output_enable, 1'b0, "other fault");
        other_fault = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk1(output_enable, 1'b1, "back on");
        print_verdict();
    end
endmodule : aux_monitor_voltage_uv_fault_and_write_lock_tb
`default_nettype wire

// file: test/uv_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Management-bus host: issues one command at a time on the command port.
module uv_host_model (
    input wire logic ref_clk, // System clock.
    output logic cmd_valid, // Command strobe.
    output logic cmd_write, // Write select.
    output logic [7:0] cmd_code, // Command code.
    output logic [uv_lock_pkg::PRIVATE_PW_BITS-1:0] cmd_wdata, // Write data.
    input wire logic rsp_valid, // Answer strobe.
    input wire logic [7:0] rsp_rdata, // Read data.
    input wire logic rsp_refused // Refusal flag.
);
    import uv_lock_pkg::*;

    // Idle bus at time zero.
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = '0;
    end

    // One transfer; passwords go out whole so the device can unlock.
    // host password
    task automatic xfer(input logic w, input logic [7:0] code,
        input logic [PRIVATE_PW_BITS-1:0] data, output logic [7:0] rd, output logic refd);
    begin
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = code;
        cmd_wdata = data;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        // Released lines show the inverse, so stale data never looks valid.
        cmd_code = ~code;
        cmd_wdata = ~data;
        rd = rsp_valid ? rsp_rdata : 8'hEE;
        refd = rsp_valid ? rsp_refused : 1'bx;
    end
    endtask : xfer
endmodule : uv_host_model
`default_nettype wire

// file: test/uv_lock_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the command port and the fault outputs of the block from its pins.
module uv_lock_monitor (
    input wire logic ref_clk, // System clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic cmd_valid, // Command strobe.
    input wire logic cmd_write, // Write select.
    input wire logic [7:0] cmd_code, // Command code.
    input wire logic rsp_valid, // Answer strobe.
    input wire logic rsp_refused, // Refusal flag.
    input wire logic commanded_on, // Output commanded on.
    input wire logic bias_ok, // Bias present.
    input wire logic other_fault, // Other fault.
    input wire logic output_enable, // Stage enable.
    input wire logic alert_output_line_n, // Alert, active low.
    input wire logic aux_uv_fault_flag, // Sticky undervoltage bit.
    input wire logic comm_fault_flag // Sticky refusal bit.
);
    import uv_lock_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Each strobe gets its answer on the next edge, and none comes unasked.
    answer_next_a: assert property (cmd_valid |=> rsp_valid)
        else $error("command not answered");
    stray_answer_a: assert property (!cmd_valid |=> !rsp_valid)
        else $error("answer without command");
    read_open_a: assert property (cmd_valid && !cmd_write |=> !rsp_refused)
        else $error("read was refused");
    password_open_a: assert property (cmd_valid && cmd_write &&
        (cmd_code == CMD_PUBLIC_PASSWORD || cmd_code == CMD_PRIVATE_PASSWORD) |=> !rsp_refused)
        else $error("password write refused");
    refusal_flagged_a: assert property (rsp_valid && rsp_refused |-> ##[0:1] comm_fault_flag)
        else $error("refusal not flagged");
    // Only a clear command may drop the undervoltage bit.
    uv_flag_sticky_a: assert property (aux_uv_fault_flag &&
        !(cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS) |=> aux_uv_fault_flag)
        else $error("fault bit dropped");
    alert_follows_a: assert property ((aux_uv_fault_flag || comm_fault_flag)
        |=> !alert_output_line_n)
        else $error("alert not pulled low");
    uv_trip_off_a: assert property ($rose(aux_uv_fault_flag) |-> !output_enable)
        else $error("output left on at fault");
    forced_off_a: assert property (!commanded_on || !bias_ok || other_fault
        |=> !output_enable)
        else $error("output on while forced off");
endmodule : uv_lock_monitor

bind aux_monitor_voltage_uv_fault_and_write_lock uv_lock_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .commanded_on(commanded_on),
    .bias_ok(bias_ok), .other_fault(other_fault), .output_enable(output_enable),
    .alert_output_line_n(alert_output_line_n), .aux_uv_fault_flag(aux_uv_fault_flag),
    .comm_fault_flag(comm_fault_flag));
`default_nettype wire
